// *** rtl/hbsp_consts.svh ***
// constants for the holding brake sequencer with pwm output
`ifndef HBSP_CONSTS_SVH
`define HBSP_CONSTS_SVH
`define HBSP_CLK_HZ        32'd10000000
`define HBSP_ADR_CTRL      4'h0
`define HBSP_ADR_DOUT      4'h1
`define HBSP_ADR_T1        4'h2
`define HBSP_ADR_T2        4'h3
`define HBSP_ADR_T3        4'h4
`define HBSP_ADR_T4        4'h5
`define HBSP_ADR_FREQ      4'h6
`define HBSP_ADR_DUTY      4'h7
`define HBSP_ADR_STAT      4'h8
`define HBSP_AUTO_BIT      2
`define HBSP_MANUAL_BIT    0
`define HBSP_FREQ_MIN      16'd50
`define HBSP_FREQ_MAX      16'd2000
`define HBSP_DUTY_MIN      7'd2
`define HBSP_DUTY_MAX      7'd100
`define HBSP_FREQ_RST      16'd1000
`define HBSP_DUTY_RST      7'd100
`define HBSP_CTRL_RST      32'h00000004
`define HBSP_TICK_CYC      16'd10000
`define HBSP_PCT_FULL      64'd100
`endif

// *** rtl/hbsp_pkg.sv ***
// types for the holding brake sequencer
package hbsp_pkg;
  typedef enum logic [2:0] {
    HBSP_IDLE    = 3'b000,
    HBSP_PRE     = 3'b001,
    HBSP_POST    = 3'b010,
    HBSP_RUN     = 3'b011,
    HBSP_STOP    = 3'b100,
    HBSP_ENGAGE  = 3'b101
  } hbsp_state_t;
  typedef struct packed {
    logic current_on;
    logic brake_released;
    logic motion_ok;
    logic stop_req;
  } hbsp_drive_t;
endpackage : hbsp_pkg

// *** rtl/hbsp_top.sv ***
// brake sequencer with pwm output and wishbone registers
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "hbsp_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - auto: release brake entering/in operation, and while stopping after a release until the first stop delay ends
// - ctrl bit 2 set selects automatic brake
// - bit 2 clear: digital output bit 0 drives brake
// - enable: current, delay, release, delay, run
// - disable: stop, delay, engage, delay, current off
// - released brake output is pwm
// - frequency in hertz, 50 to 2000 only
// - duty in percent, 2 to 100 only
// - duty 100 holds output steadily on
module hbsp_top #(
  parameter int TICK_CYC = `HBSP_TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        enable_req_i,
  input  wire logic        standstill_i,
  output logic             brake_o,
  output logic             current_on_o,
  output logic             motion_ok_o,
  output logic             stop_req_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]           ctrl_reg;
  logic [31:0]           dout_reg;
  logic [15:0]           t1_reg;
  logic [15:0]           t2_reg;
  logic [15:0]           t3_reg;
  logic [15:0]           t4_reg;
  logic [15:0]           freq_reg;
  logic [6:0]            duty_reg;
  logic                  ack_reg;
  logic [31:0]           rdat_reg;
  logic [1:0]            en_sync_reg;
  logic [1:0]            ss_sync_reg;
  hbsp_pkg::hbsp_state_t state_reg;
  hbsp_pkg::hbsp_state_t state_next;
  logic [15:0]           ms_cnt_reg;
  logic [15:0]           wait_reg;
  logic [31:0]           pwm_cnt_reg;
  logic                  rel_seen_reg;
  hbsp_pkg::hbsp_drive_t drv_reg;
  hbsp_pkg::hbsp_drive_t drv_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  // timer words only take the low half; a write to the upper lanes alone keeps them
  function automatic logic [15:0] take_low16(input logic [15:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0] | sel[1]) begin
      r = nw[15:0];
    end
    return r;
  endfunction : take_low16

  // the whole written word must lie in range, so stray upper bits also refuse it
  function automatic logic in_range(input logic [31:0] val, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (val >= lo) && (val <= hi);
  endfunction : in_range

  wire         wr        = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  wire         rd        = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
  wire  [31:0] wd_ctrl   = merge(ctrl_reg, wb_dat_i, wb_sel_i);
  wire  [31:0] wd_dout   = merge(dout_reg, wb_dat_i, wb_sel_i);
  wire  [31:0] wd_t1     = merge({16'h0000, t1_reg}, wb_dat_i, wb_sel_i);
  wire  [15:0] wd_t2     = take_low16(t2_reg, wb_dat_i, wb_sel_i);
  wire  [15:0] wd_t3     = take_low16(t3_reg, wb_dat_i, wb_sel_i);
  wire  [15:0] wd_t4     = take_low16(t4_reg, wb_dat_i, wb_sel_i);
  wire  [31:0] wd_freq   = merge({16'h0000, freq_reg}, wb_dat_i, wb_sel_i);
  wire  [31:0] wd_duty   = merge({25'h0000000, duty_reg}, wb_dat_i, wb_sel_i);
  wire         freq_ok   = in_range(wd_freq, 32'(`HBSP_FREQ_MIN), 32'(`HBSP_FREQ_MAX));
  wire         duty_ok   = in_range(wd_duty, 32'(`HBSP_DUTY_MIN), 32'(`HBSP_DUTY_MAX));
  wire         auto_mode = ctrl_reg[`HBSP_AUTO_BIT];
  wire         en_s      = en_sync_reg[1];
  wire         ss_s      = ss_sync_reg[1];

  // register bus, one wait state, unmapped reads give zero, writes dropped
  wire hit_ctrl = wr && (wb_adr_i == `HBSP_ADR_CTRL);
  wire hit_dout = wr && (wb_adr_i == `HBSP_ADR_DOUT);
  wire hit_t1   = wr && (wb_adr_i == `HBSP_ADR_T1);
  wire hit_t2   = wr && (wb_adr_i == `HBSP_ADR_T2);
  wire hit_t3   = wr && (wb_adr_i == `HBSP_ADR_T3);
  wire hit_t4   = wr && (wb_adr_i == `HBSP_ADR_T4);
  wire hit_freq = wr && (wb_adr_i == `HBSP_ADR_FREQ) && freq_ok;
  wire hit_duty = wr && (wb_adr_i == `HBSP_ADR_DUTY) && duty_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `HBSP_CTRL_RST;
    end else if (hit_ctrl) begin
      ctrl_reg <= wd_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_reg <= 32'h00000000;
    end else if (hit_dout) begin
      dout_reg <= wd_dout;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1_reg <= 16'h0000;
    end else if (hit_t1) begin
      t1_reg <= wd_t1[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t2_reg <= 16'h0000;
    end else if (hit_t2) begin
      t2_reg <= wd_t2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t3_reg <= 16'h0000;
    end else if (hit_t3) begin
      t3_reg <= wd_t3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t4_reg <= 16'h0000;
    end else if (hit_t4) begin
      t4_reg <= wd_t4;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_reg <= `HBSP_FREQ_RST;
    end else if (hit_freq) begin
      freq_reg <= wd_freq[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_reg <= `HBSP_DUTY_RST;
    end else if (hit_duty) begin
      duty_reg <= wd_duty[6:0];
    end
  end

  wire [31:0] rmux =
      (wb_adr_i == `HBSP_ADR_CTRL) ? ctrl_reg :
      (wb_adr_i == `HBSP_ADR_DOUT) ? dout_reg :
      (wb_adr_i == `HBSP_ADR_T1)   ? {16'h0000, t1_reg} :
      (wb_adr_i == `HBSP_ADR_T2)   ? {16'h0000, t2_reg} :
      (wb_adr_i == `HBSP_ADR_T3)   ? {16'h0000, t3_reg} :
      (wb_adr_i == `HBSP_ADR_T4)   ? {16'h0000, t4_reg} :
      (wb_adr_i == `HBSP_ADR_FREQ) ? {16'h0000, freq_reg} :
      (wb_adr_i == `HBSP_ADR_DUTY) ? {25'h0000000, duty_reg} :
      (wb_adr_i == `HBSP_ADR_STAT) ? {25'h0000000, state_reg, drv_reg.brake_released,
                                      drv_reg.current_on, drv_reg.motion_ok,
                                      drv_reg.stop_req} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg  <= (wr | rd);
      rdat_reg <= rd ? rmux : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // enable request and standstill come from the drive core's other timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_sync_reg <= 2'b00;
      ss_sync_reg <= 2'b00;
    end else begin
      en_sync_reg <= {en_sync_reg[0], enable_req_i};
      ss_sync_reg <= {ss_sync_reg[0], standstill_i};
    end
  end

  // delays count in milliseconds; a new phase restarts the prescaler
  wire ms_tick   = (ms_cnt_reg == 16'(TICK_CYC - 1));
  wire wait_done = (wait_reg == 16'h0000);
  logic [15:0] wait_load;
  logic        load;

  always_comb begin
    state_next = state_reg;
    load       = 1'b0;
    wait_load  = 16'h0000;
    case (state_reg)
      hbsp_pkg::HBSP_IDLE: if (en_s) begin
        state_next = hbsp_pkg::HBSP_PRE;
        load = 1'b1;
        wait_load = t3_reg;
      end
      hbsp_pkg::HBSP_PRE: if (!en_s) begin
        state_next = hbsp_pkg::HBSP_STOP;
      end else if (wait_done) begin
        state_next = hbsp_pkg::HBSP_POST;
        load = 1'b1;
        wait_load = t4_reg;
      end
      hbsp_pkg::HBSP_POST: if (!en_s) begin
        state_next = hbsp_pkg::HBSP_STOP;
      end else if (wait_done) begin
        state_next = hbsp_pkg::HBSP_RUN;
      end
      hbsp_pkg::HBSP_RUN: if (!en_s) begin
        state_next = hbsp_pkg::HBSP_STOP;
      end
      hbsp_pkg::HBSP_STOP: if (ss_s) begin
        state_next = hbsp_pkg::HBSP_ENGAGE;
        load = 1'b1;
        wait_load = t1_reg;
      end
      hbsp_pkg::HBSP_ENGAGE: if (wait_done) begin
        state_next = hbsp_pkg::HBSP_IDLE;
        load = 1'b1;
        wait_load = t2_reg;
      end
      default: state_next = hbsp_pkg::HBSP_IDLE;
    endcase
  end

  // second-delay phase: idle with nonzero wait keeps current on, brake on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= hbsp_pkg::HBSP_IDLE;
      ms_cnt_reg <= 16'h0000;
      wait_reg   <= 16'h0000;
    end else begin
      state_reg  <= state_next;
      ms_cnt_reg <= (load | ms_tick) ? 16'h0000 : ms_cnt_reg + 16'h0001;
      if (load) wait_reg <= wait_load;
      else if (ms_tick && !wait_done) wait_reg <= wait_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm period in cycles, recomputed live; division done once per cycle
  wire [31:0] period   = `HBSP_CLK_HZ / {16'h0000, freq_reg};
  wire [31:0] on_time  = 32'((64'(period) * 64'(duty_reg)) / `HBSP_PCT_FULL);
  wire        pwm_wave = (duty_reg == `HBSP_DUTY_MAX) ? 1'b1 : (pwm_cnt_reg < on_time);
  wire        pwm_wrap = (pwm_cnt_reg >= period - 32'd1);
  // the brake stays released while the shaft comes to rest and through the
  // first stop delay, but only if it was ever lifted: an enable withdrawn
  // during the pre-release delay must never release it
  wire in_release    = (state_reg == hbsp_pkg::HBSP_POST) ||
                       (state_reg == hbsp_pkg::HBSP_RUN);
  wire in_leave      = (state_reg == hbsp_pkg::HBSP_STOP) ||
                       (state_reg == hbsp_pkg::HBSP_ENGAGE);
  wire released_auto = in_release || (in_leave && rel_seen_reg);
  wire released      = auto_mode ? released_auto : dout_reg[`HBSP_MANUAL_BIT];

  assign drv_next = '{current_on:     (state_reg != hbsp_pkg::HBSP_IDLE) || !wait_done,
                      brake_released: released & pwm_wave,
                      motion_ok:      (state_next == hbsp_pkg::HBSP_RUN),
                      stop_req:       (state_next == hbsp_pkg::HBSP_STOP)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_cnt_reg  <= 32'h00000000;
      rel_seen_reg <= 1'b0;
      drv_reg      <= hbsp_pkg::hbsp_drive_t'(4'h0);
    end else begin
      pwm_cnt_reg  <= (!released || pwm_wrap) ? 32'h00000000 : pwm_cnt_reg + 32'd1;
      rel_seen_reg <= released_auto;
      drv_reg      <= drv_next;
    end
  end
  assign brake_o      = drv_reg.brake_released;
  assign current_on_o = drv_reg.current_on;
  assign motion_ok_o  = drv_reg.motion_ok;
  assign stop_req_o   = drv_reg.stop_req;
endmodule : hbsp_top

// *** tb/hbsp_monitor.sv ***
// port assertions for the brake sequencer
`timescale 1ns/1ps
module hbsp_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:2]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        brake_o,
  input wire logic        current_on_o,
  input wire logic        motion_ok_o,
  input wire logic        stop_req_o
);
  logic auto_reg;
  // copied at the ack edge, one cycle after ctrl_reg, the same edge at which brake_o follows the new mode
  always_ff @(posedge clk_i)
    if (rst_i) auto_reg <= 1'b1;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 4'h0)
      auto_reg <= wb_dat_i[2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  a_release_current: assert property (auto_reg && brake_o |-> current_on_o)
    else $error("brake released without current");
  a_motion_current: assert property (motion_ok_o |-> current_on_o && !stop_req_o)
    else $error("motion without current");
  a_stop_current: assert property (stop_req_o |-> current_on_o && !motion_ok_o)
    else $error("stop without current");
  a_current_first: assert property (
    auto_reg && $rose(current_on_o) |-> !brake_o && !motion_ok_o) else $error("current not first");
  a_current_last: assert property (auto_reg && $fell(current_on_o) |-> !brake_o)
    else $error("current off before engage");
endmodule : hbsp_monitor
bind hbsp_top hbsp_monitor hbsp_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .brake_o(brake_o),
  .current_on_o(current_on_o), .motion_ok_o(motion_ok_o), .stop_req_o(stop_req_o));

// *** tb/hbsp_brake_model.sv ***
// motor shaft with holding brake, coming to rest on a stop request
`timescale 1ns/1ps
module hbsp_brake_model (
  input  wire logic       clk_i,
  input  wire logic       current_on_i,
  input  wire logic       stop_req_i,
  input  wire logic [7:0] delay_i,
  output logic            standstill_o
);
  logic [7:0] cnt_reg;
  initial standstill_o = 1'b1;
  // coasting time is set per run so both prompt and slow stops are seen
  always @(posedge clk_i) begin
    if (!stop_req_i) begin
      cnt_reg      <= 8'h00;
      standstill_o <= !current_on_i;
    end else if (cnt_reg == delay_i) begin
      standstill_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : hbsp_brake_model

// *** tb/tb.sv ***
// self-checking bench for the brake sequencer
`timescale 1ns/1ps
`include "hbsp_consts.svh"
module tb;
  localparam int TICK = 10;
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, enable_req_i = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, v, wb_dat_o, fexp = `HBSP_FREQ_RST, dexp = `HBSP_DUTY_RST;
  logic        wb_ack_o, standstill_i, brake_o, current_on_o, motion_ok_o, stop_req_o;
  logic [7:0]  mdel = 8'h02;
  logic [31:0] fv[4] = '{32'h31, 32'h7D1, 32'h32, 32'h7D0};
  logic [31:0] dv[4] = '{32'h1, 32'h65, 32'h2, 32'h64};
  int          failures = 0, checked = 0, seed = 43749, n, t[4];
  wire  [3:0]  outs = {brake_o, current_on_o, motion_ok_o, stop_req_o};
  always #50 clk_i = !clk_i;
  hbsp_top #(.TICK_CYC(TICK)) hbsp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enable_req_i(enable_req_i),
    .standstill_i(standstill_i), .brake_o(brake_o), .current_on_o(current_on_o),
    .motion_ok_o(motion_ok_o), .stop_req_o(stop_req_o));
  hbsp_brake_model hbsp_brake_model_inst (.clk_i(clk_i), .current_on_i(current_on_o),
    .stop_req_i(stop_req_o), .delay_i(mdel), .standstill_o(standstill_i));
  task stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol);
    checked++;
    if (^g === 1'bx || g > e + tol || g + tol < e) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    req <= 1'b0;
  endtask : wb
  task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdat, 0);
  endtask : rchk
  // bounded wait on one output, cycle count left in n
  task wt(input int k, input logic l);
    n = 0;
    while (outs[k] !== l && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      $display("wrong value output %0d expected %0d seen timeout", k, l);
    end
  endtask : wt
  function logic [31:0] keep(input logic [31:0] x, lo, hi, old);
    return (x >= lo && x <= hi) ? x : old;
  endfunction : keep
  function int pwm_hi(input int f, input int d);
    return (`HBSP_CLK_HZ / f) * d / 100;
  endfunction : pwm_hi
  task run_seq(input logic [7:0] del);
    mdel <= del;
    for (int i = 0; i < 4; i++) begin
      t[i] = 1 + $unsigned($random(seed)) % 3;
      wb(1'b1, 4'h2 + i[3:0], t[i]);
    end
    enable_req_i <= 1'b1;
    wt(2, 1'b1);
    wt(3, 1'b1);
    chk("pre release", t[2] * TICK, n, 3);
    wt(1, 1'b1);
    chk("post release", t[3] * TICK, n, 3);
    n = 0;
    repeat (50) begin
      @(posedge clk_i);
      n += !brake_o;
    end
    chk("steady brake", 0, n, 0);
    enable_req_i <= 1'b0;
    wt(0, 1'b1);
    wt(0, 1'b0);
    wt(3, 1'b0);
    chk("engage delay", t[0] * TICK, n, 3);
    wt(2, 1'b0);
    chk("current off delay", t[1] * TICK, n, 3);
  endtask : run_seq
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("ctrl reset", `HBSP_ADR_CTRL, `HBSP_CTRL_RST);
    rchk("unmapped", 4'hF, 32'h0);
    rchk("status", `HBSP_ADR_STAT, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? fv[i] : $unsigned($random(seed)) % 2200;
      fexp = keep(v, `HBSP_FREQ_MIN, `HBSP_FREQ_MAX, fexp);
      wb(1'b1, `HBSP_ADR_FREQ, v);
      rchk("freq", `HBSP_ADR_FREQ, fexp);
      v = (i < 4) ? dv[i] : $unsigned($random(seed)) % 110;
      dexp = keep(v, `HBSP_DUTY_MIN, `HBSP_DUTY_MAX, dexp);
      wb(1'b1, `HBSP_ADR_DUTY, v);
      rchk("duty", `HBSP_ADR_DUTY, dexp);
    end
    wb(1'b1, `HBSP_ADR_DUTY, 32'h64);
    run_seq(8'h02);
    run_seq(8'h28);
    enable_req_i <= 1'b1;
    wt(2, 1'b1);
    enable_req_i <= 1'b0;
    n = 0;
    repeat (200) begin
      @(posedge clk_i);
      n += brake_o;
    end
    chk("abort brake", 0, n, 0);
    chk("abort current", 0, current_on_o, 0);
    wb(1'b1, `HBSP_ADR_DOUT, 32'h0);
    wb(1'b1, `HBSP_ADR_CTRL, 32'h0);
    wb(1'b1, `HBSP_ADR_DOUT, 32'h1);
    wt(3, 1'b1);
    chk("manual brake", 1, brake_o, 0);
    wb(1'b1, `HBSP_ADR_CTRL, 32'h4);
    wt(3, 1'b0);
    chk("auto brake idle", 0, brake_o, 0);
    wb(1'b1, `HBSP_ADR_DOUT, 32'h0);
    wb(1'b1, `HBSP_ADR_FREQ, 32'h7D0);
    wb(1'b1, `HBSP_ADR_DUTY, 32'h19);
    enable_req_i <= 1'b1;
    wt(1, 1'b1);
    wt(3, 1'b0);
    wt(3, 1'b1);
    wt(3, 1'b0);
    chk("pwm high", pwm_hi(2000, 25), n, 2);
    wt(3, 1'b1);
    chk("pwm low", pwm_hi(2000, 75), n, 2);
    enable_req_i <= 1'b0;
    wt(2, 1'b0);
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    stop_test;
  end
endmodule : tb
